// File: hw/clock_gen_status_flags.sv
// clock generator status register, sticky flags and pending-interrupt flag on apb
// assumes raw clock-generator status pins are asynchronous to core_clk
`timescale 1ns/100ps
module clock_gen_status_flags (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// raw clock generator status
	input wire logic [1:0] raw_mode,
	input wire logic raw_ref_xtal,
	input wire logic raw_lock,
	input wire logic raw_lock_lost,
	input wire logic raw_clock_lost,
	input wire logic raw_ext_good,
	// control to the clock generator
	output logic [1:0] clock_mode_select,
	output logic lock_loss_reset_enable,
	output logic clock_loss_reset_enable,
	// reset requests from sticky losses
	output logic lock_loss_reset_req,
	output logic clock_loss_reset_req,
	// interrupt request
	output logic clkgen_irq
);
	logic rst_meta_q, rst_n_q;
	logic [3:0] control_q;
	logic lock_loss_sticky_q, clock_loss_sticky_q, clkgen_irq_flag_q;
	logic armed_q;
	logic ext_s1_q, ext_s2_q, ext_s3_q, ext_good_q;
	logic [31:0] prdata_q;
	logic pready_q, pslverr_q, irq_q, lolr_q, locr_q;

	clkgen_sync_if sif ();

	////////////////////////////////////////////////////////////////////
	// reset release through two flops
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_meta_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n_q <= rst_meta_q;
		end
	end

	////////////////////////////////////////////////////////////////////
	// synchronise raw status
	clkgen_sync u_sync (
		.core_clk(core_clk),
		.rst_n(rst_n_q),
		.raw_in({raw_clock_lost, raw_lock_lost, raw_lock, raw_ref_xtal, raw_mode}),
		.out(sif)
	);

	// external reference good, three flops and agreement filter
	always_ff @(posedge core_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			ext_s1_q <= 1'b0;
			ext_s2_q <= 1'b0;
			ext_s3_q <= 1'b0;
			ext_good_q <= 1'b0;
		end else begin
			ext_s1_q <= raw_ext_good;
			ext_s2_q <= ext_s1_q;
			ext_s3_q <= ext_s2_q;
			if (ext_s2_q == ext_s3_q) begin
				ext_good_q <= ext_s3_q;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// apb decode
	wire setup = psel & ~penable;
	wire access = psel & penable;
	wire hit_status = (paddr == clkgen_pkg::status_one_addr);
	wire hit_control = (paddr == clkgen_pkg::control_addr);
	wire hit_any = hit_status | hit_control;
	wire wr_status = access & pwrite & hit_status & pready_q;
	wire wr_control = access & pwrite & hit_control & pready_q;
	wire rd_status = access & ~pwrite & hit_status & pready_q;

	// lock bit is forced low outside fll modes
	wire fll_mode = (sif.mode == clkgen_pkg::mode_fll_int) |
		(sif.mode == clkgen_pkg::mode_fll_ext);
	wire lock_view = sif.lock & fll_mode;

	// any new event raises the pending interrupt
	wire irq_event = sif.lol_evt | sif.loc_evt;
	wire clr_one = wr_status & pwdata[clkgen_pkg::irq_bit];
	wire sticky_clr = wr_status;

	// status byte assembly
	wire [7:0] status_byte = {sif.mode, sif.ref_xtal, lock_loss_sticky_q, lock_view,
		clock_loss_sticky_q, ext_good_q, clkgen_irq_flag_q};

	wire [31:0] rd_word = hit_status ? {24'h00_0000, status_byte} :
		hit_control ? {28'h000_0000, control_q} : clkgen_pkg::zero_word;

	////////////////////////////////////////////////////////////////////
	// control register
	always_ff @(posedge core_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			control_q <= clkgen_pkg::control_reset;
		end else if (wr_control) begin
			control_q <= pwdata[3:0];
		end
	end

	////////////////////////////////////////////////////////////////////
	// sticky loss flags, set wins over clear by writing one to the bit
	always_ff @(posedge core_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			lock_loss_sticky_q <= 1'b0;
			clock_loss_sticky_q <= 1'b0;
		end else begin
			if (sif.lol_evt) begin
				lock_loss_sticky_q <= 1'b1;
			end else if (sticky_clr & pwdata[clkgen_pkg::lol_bit]) begin
				lock_loss_sticky_q <= 1'b0;
			end
			if (sif.loc_evt) begin
				clock_loss_sticky_q <= 1'b1;
			end else if (sticky_clr & pwdata[clkgen_pkg::loc_bit]) begin
				clock_loss_sticky_q <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// interrupt flag with read-then-write-one clearing
	always_ff @(posedge core_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			clkgen_irq_flag_q <= 1'b0;
			armed_q <= 1'b0;
		end else begin
			if (irq_event) begin
				clkgen_irq_flag_q <= 1'b1;
				armed_q <= 1'b0;
			end else if (clr_one & armed_q) begin
				clkgen_irq_flag_q <= 1'b0;
				armed_q <= 1'b0;
			end else if (rd_status & prdata_q[clkgen_pkg::irq_bit]) begin
				// arm only if the word software saw had the flag set
				armed_q <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// apb answer: no wait state, ready in the first access cycle
	always_ff @(posedge core_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= clkgen_pkg::zero_word;
		end else begin
			pready_q <= setup;
			pslverr_q <= setup & ~hit_any;
			if (setup & ~pwrite) begin
				prdata_q <= rd_word;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// registered outputs
	always_ff @(posedge core_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			irq_q <= 1'b0;
			lolr_q <= 1'b0;
			locr_q <= 1'b0;
		end else begin
			irq_q <= clkgen_irq_flag_q | irq_event;
			lolr_q <= lock_loss_sticky_q & control_q[clkgen_pkg::lock_loss_reset_enable_bit];
			locr_q <= clock_loss_sticky_q & control_q[clkgen_pkg::clock_loss_reset_enable_bit];
		end
	end

	// port assignments
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign clkgen_irq = irq_q;
	assign lock_loss_reset_req = lolr_q;
	assign clock_loss_reset_req = locr_q;
	assign clock_mode_select = control_q[clkgen_pkg::sel_hi_bit:clkgen_pkg::sel_lo_bit];
	assign lock_loss_reset_enable = control_q[clkgen_pkg::lock_loss_reset_enable_bit];
	assign clock_loss_reset_enable = control_q[clkgen_pkg::clock_loss_reset_enable_bit];
endmodule

// File: hw/clkgen_pkg.sv
// package of offsets, field positions and reset values for the clock generator status block
// assumes an apb slave with 32-bit data, one aligned word per register
package clkgen_pkg;
	// register byte addresses
	localparam logic [7:0] status_one_addr = 8'h00;
	localparam logic [7:0] control_addr = 8'h04;
	// status field positions
	localparam int mode_hi_bit = 7;
	localparam int mode_lo_bit = 6;
	localparam int ref_bit = 5;
	localparam int lol_bit = 4;
	localparam int lock_bit = 3;
	localparam int loc_bit = 2;
	localparam int ext_good_bit = 1;
	localparam int irq_bit = 0;
	// control field positions
	localparam int sel_lo_bit = 0;
	localparam int sel_hi_bit = 1;
	localparam int lock_loss_reset_enable_bit = 2;
	localparam int clock_loss_reset_enable_bit = 3;
	// clock mode codes
	localparam logic [1:0] mode_self = 2'h0;
	localparam logic [1:0] mode_fll_int = 2'h1;
	localparam logic [1:0] mode_byp_ext = 2'h2;
	localparam logic [1:0] mode_fll_ext = 2'h3;
	// reset values
	localparam logic [1:0] mode_reset = 2'h0;
	localparam logic [3:0] control_reset = 4'h0;
	localparam logic [31:0] zero_word = 32'h0000_0000;
endpackage

// File: hw/clkgen_sync_if.sv
// interface carrying one synchronised status bundle between modules
// assumes both ends run on core_clk
`timescale 1ns/100ps
interface clkgen_sync_if;
	logic [1:0] mode;
	logic ref_xtal;
	logic lock;
	logic lol_evt;
	logic loc_evt;
	modport src (output mode, ref_xtal, lock, lol_evt, loc_evt);
	modport dst (input mode, ref_xtal, lock, lol_evt, loc_evt);
endinterface

// File: hw/clkgen_sync.sv
// three-stage synchronisers for the clock generator's raw status pins except raw_ext_good
// assumes raw inputs come from another clock domain; events are rising edges
`timescale 1ns/100ps
module clkgen_sync (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// raw inputs
	input wire logic [5:0] raw_in,
	// synchronised output
	clkgen_sync_if.src out
);
	logic [5:0] s1_q, s2_q, s3_q, stable_q, prev_q;
	logic [5:0] agree;

	// three flops per bit
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end else begin
			s1_q <= raw_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// a change counts once second and third stages agree
	genvar i;
	generate
		for (i = 0; i < 6; i++) begin : g_bit
			assign agree[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : stable_q[i];
		end
	endgenerate

	// stable copy and its previous value for edge events
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			stable_q <= '0;
			prev_q <= '0;
		end else begin
			stable_q <= agree;
			prev_q <= stable_q;
		end
	end

	// mode lags the raw_mode pins through the sync chain
	assign out.mode = stable_q[1:0];
	assign out.ref_xtal = stable_q[2];
	assign out.lock = stable_q[3];
	assign out.lol_evt = stable_q[4] & ~prev_q[4];
	assign out.loc_evt = stable_q[5] & ~prev_q[5];
endmodule

// File: tb/clkgen_status_sva.sv
// assertions on the apb answer and flag outputs of the status block
// assumes it is bound to clock_gen_status_flags
`timescale 1ns/100ps
module clkgen_status_sva (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// control and flags
	input wire logic [1:0] clock_mode_select,
	input wire logic lock_loss_reset_enable,
	input wire logic clock_loss_reset_enable,
	input wire logic lock_loss_reset_req,
	input wire logic clock_loss_reset_req,
	input wire logic clkgen_irq
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	////////////////////////////////////////////////////////////////
	// completed accesses by kind
	wire done = psel && penable && pready;
	wire st_a = paddr == clkgen_pkg::status_one_addr;
	wire ct_a = paddr == clkgen_pkg::control_addr;
	wire st_rd = done && !pwrite && st_a;
	wire ct_rd = done && !pwrite && ct_a;
	wire st_wr1 = done && pwrite && st_a && pwdata[0];
	wire [31:0] ctl = {28'h000_0000, clock_loss_reset_enable, lock_loss_reset_enable,
		clock_mode_select};
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_answer;
		pready ##1 !pready;
	endsequence
	property p_answer;
		s_setup |=> s_answer;
	endproperty
	property p_one;
		pready |=> !pready;
	endproperty
	property p_refuse;
		done && !st_a && !ct_a |-> pslverr && (pwrite || prdata == clkgen_pkg::zero_word);
	endproperty
	property p_ctrl;
		ct_rd |-> !pslverr && prdata == ctl;
	endproperty
	property p_lock;
		st_rd && !prdata[6] |-> !prdata[3];
	endproperty
	property p_lol_req;
		!lock_loss_reset_enable [*3] |-> !lock_loss_reset_req;
	endproperty
	property p_loc_req;
		!clock_loss_reset_enable [*3] |-> !clock_loss_reset_req;
	endproperty
	property p_irq_fall;
		$fell(clkgen_irq) |-> $past(st_wr1, 1) || $past(st_wr1, 2) || $past(st_wr1, 3);
	endproperty
	a_answer: assert property (p_answer) else $error("pready not in first access cycle");
	a_one: assert property (p_one) else $error("pready longer than one cycle");
	a_refuse: assert property (p_refuse) else $error("unmapped access not refused");
	a_ctrl: assert property (p_ctrl) else $error("control readback differs from outputs");
	a_lock: assert property (p_lock) else $error("lock shown outside loop modes");
	a_lol_req: assert property (p_lol_req) else $error("lock loss request while off");
	a_loc_req: assert property (p_loc_req) else $error("clock loss request while off");
	a_irq_fall: assert property (p_irq_fall) else $error("irq fell without clear");
endmodule
bind clock_gen_status_flags clkgen_status_sva u_sva (.core_clk, .reset_n, .psel, .penable,
	.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .clock_mode_select,
	.lock_loss_reset_enable, .clock_loss_reset_enable, .lock_loss_reset_req,
	.clock_loss_reset_req, .clkgen_irq);

// File: tb/test_clock_gen_status_flags.sv
// bench for the clock generator status block, one task per scenario
// assumes ready in the first apb access cycle and about five edges of input latency
`timescale 1ns/100ps
module test_clock_gen_status_flags;
	logic core_clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
	logic raw_ref_xtal = 0, raw_lock = 0, raw_lock_lost = 0, raw_clock_lost = 0;
	logic raw_ext_good = 0, lock_loss_reset_enable, clock_loss_reset_enable, err;
	logic lock_loss_reset_req, clock_loss_reset_req, clkgen_irq;
	logic [1:0] raw_mode = 2'h0, clock_mode_select;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
	int n_errors = 0, samples_checked = 0;
	clock_gen_status_flags dut (.core_clk, .reset_n, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .raw_mode, .raw_ref_xtal, .raw_lock,
		.raw_lock_lost, .raw_clock_lost, .raw_ext_good, .clock_mode_select,
		.lock_loss_reset_enable, .clock_loss_reset_enable, .lock_loss_reset_req,
		.clock_loss_reset_req, .clkgen_irq);
	// 50 MHz clock
	initial begin
		forever #10 core_clk = ~core_clk;
	end
	////////////////////////////////////////////////////////////////
	// verdict, compare, wait, reset and apb master
	task automatic complete_run;
		if (n_errors == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, g);
		samples_checked++;
		if (g !== e) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	task automatic do_reset;
		reset_n <= 0;
		cyc(20);
		reset_n <= 1;
		cyc(4);
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge core_clk);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		@(posedge core_clk);
		penable <= 1;
		for (i = 0; i < 20; i++) begin
			@(posedge core_clk);
			if (pready === 1'b1) break;
		end
		if (i == 20) begin
			n_errors++;
			complete_run;
		end
		{rd, err} = {prdata, pslverr};
		{psel, penable} <= 2'h0;
	endtask
	task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		chk(n, e, rd);
	endtask
	task automatic pulse(input logic c);
		{raw_clock_lost, raw_lock_lost} <= {c, !c};
		cyc(8);
		{raw_clock_lost, raw_lock_lost} <= 2'h0;
		cyc(12);
	endtask
	////////////////////////////////////////////////////////////////
	// scenarios
	task automatic s_modes;
		raw_lock <= 1;
		cyc(10);
		for (int i = 0; i < 4; i++) begin
			raw_mode <= 2'(i + 1);
			rdc("mode_early", 8'h00, {24'h00_0000, 2'(i), 2'h0, i[0], 3'h0});
			apb(1'b1, 8'h04, 32'((i + 1) % 4));
			cyc(10);
			chk("select", 32'((i + 1) % 4), 32'(clock_mode_select));
			rdc("mode", 8'h00, {24'h00_0000, 2'(i + 1), 2'h0, !i[0], 3'h0});
		end
	endtask
	task automatic s_ref;
		raw_ref_xtal <= 1;
		cyc(10);
		rdc("ref", 8'h00, 32'h0000_0020);
		{raw_ref_xtal, raw_ext_good} <= 2'h1;
		cyc(10);
		rdc("ext", 8'h00, 32'h0000_0002);
		raw_ext_good <= 0;
		cyc(10);
	endtask
	task automatic s_refuse;
		apb(1'b1, 8'h08, 32'h0000_000f);
		chk("err_wr", 1, err);
		rdc("unmapped", 8'h08, 32'h0000_0000);
		chk("err_rd", 1, err);
		rdc("control", 8'h04, 32'h0000_0000);
		chk("err_ok", 0, err);
	endtask
	task automatic s_irq;
		pulse(0);
		rdc("lol", 8'h00, 32'h0000_0011);
		chk("irq_on", 1, clkgen_irq);
		apb(1'b1, 8'h00, 32'h0000_0000);
		rdc("zero_wr", 8'h00, 32'h0000_0011);
		pulse(1);
		apb(1'b1, 8'h00, 32'h0000_0001);
		rdc("restart", 8'h00, 32'h0000_0015);
		apb(1'b1, 8'h00, 32'h0000_0001);
		cyc(3);
		rdc("cleared", 8'h00, 32'h0000_0014);
		chk("irq_off", 0, clkgen_irq);
		pulse(0);
		apb(1'b1, 8'h00, 32'h0000_0001);
		rdc("no_read", 8'h00, 32'h0000_0015);
		apb(1'b1, 8'h04, 32'h0000_000c);
		cyc(3);
		chk("reqs", 3, {lock_loss_reset_req, clock_loss_reset_req});
		do_reset;
		rdc("reset", 8'h00, 32'h0000_0000);
		chk("irq_rst", 0, clkgen_irq);
	endtask
	// main sequence
	initial begin
		do_reset;
		rdc("idle", 8'h00, 32'h0000_0000);
		s_modes;
		s_ref;
		s_refuse;
		s_irq;
		complete_run;
	end
endmodule
